// *** pkg/iox_defines.svh ***
// Constants of the serial I/O expander: command codes, reset values, bus address.
// Assumes inclusion by bare name from the package and the design files.
`ifndef IOX_DEFINES_SVH
`define IOX_DEFINES_SVH

// ****************************************
// Command byte (register pointer) codes
// ****************************************
`define IOX_CMD_INPUT 8'h00
`define IOX_CMD_OUTPUT 8'h01
`define IOX_CMD_POLARITY 8'h02
`define IOX_CMD_CONFIG 8'h03

// ****************************************
// Reset values
// ****************************************
`define IOX_RST_POINTER 8'h00
`define IOX_RST_OUTPUT 8'hff
`define IOX_RST_POLARITY 8'h00
`define IOX_RST_CONFIG 8'hff

// ****************************************
// Bus address and byte framing
// ****************************************
`define IOX_ADDR_PREFIX 4'h4
`define IOX_LAST_BIT 4'h7
`define IOX_ACK_SLOT 4'h8

`endif

// *** pkg/iox_pkg.sv ***
// Types of the serial I/O expander.
// Assumes iox_defines.svh sits on the include path.
`include "iox_defines.svh"

package iox_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_CMD,
		ST_WDATA,
		ST_RDATA,
		ST_FOREIGN
	} iox_state_t;
endpackage

// *** design/iox_irq.sv ***
// Input-change interrupt of the expander, in the system clock domain.
// Assumes the clear toggle and the direction mask are held stable between changes.
`timescale 1ns/1ps
`default_nettype none

module iox_irq (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Port pins and direction (1 = input)
	input wire logic [7:0] port_pins_in,
	input wire logic [7:0] input_mask_in,
	// Clear event from the link domain
	input wire logic clr_tog_in,
	// Interrupt drive enable
	output logic irq_oe_out
);
	import iox_pkg::*;

	logic [7:0] pin_s1, pin_s2, last_read, next_last_read, diff;
	logic clr_s1, clr_s2, clr_s3, clr_pulse;
	logic armed, next_armed, next_irq_oe;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_diff
			assign diff[gi] = input_mask_in[gi] & (pin_s2[gi] ^ last_read[gi]);
		end
	endgenerate

	always_comb begin
		clr_pulse = clr_s2 ^ clr_s3;
		next_armed = 1'b1;
		next_last_read = last_read;
		// Snapshot at release of reset, then at each clear event
		if (!armed || clr_pulse) begin
			next_last_read = pin_s2;
		end
		// Clear wins over a change seen in the same cycle
		next_irq_oe = armed && !clr_pulse && (|diff);
	end

	always_ff @(posedge ref_clk_in) begin
		// Pin sync runs through reset, so the first snapshot sees real pins
		pin_s1 <= port_pins_in;
		pin_s2 <= pin_s1;
		if (rst_in) begin
			clr_s1 <= 1'b0;
			clr_s2 <= 1'b0;
			clr_s3 <= 1'b0;
			armed <= 1'b0;
			last_read <= 8'h00;
			irq_oe_out <= 1'b0;
		end else begin
			clr_s1 <= clr_tog_in;
			clr_s2 <= clr_s1;
			clr_s3 <= clr_s2;
			armed <= next_armed;
			last_read <= next_last_read;
			irq_oe_out <= next_irq_oe;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_irq_on_change: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		armed && (|diff) && !clr_pulse |=> irq_oe_out)
		else $error("interrupt not raised on input change");
	a_irq_read_clear: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		clr_pulse |=> !irq_oe_out && last_read == $past(pin_s2))
		else $error("interrupt not released on clear event");
	a_irq_return: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		armed && diff == 8'h00 |=> !irq_oe_out)
		else $error("interrupt held with inputs at last read value");
	a_snap_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		armed && !clr_pulse |=> $stable(last_read))
		else $error("last read value moved without clear");
	a_irq_reset: assert property (@(posedge ref_clk_in)
		rst_in ##1 !rst_in |-> !armed && !irq_oe_out ##1 armed)
		else $error("interrupt state not defaulted by reset");
endmodule

`default_nettype wire

// *** design/iox_expander_top.sv ***
// Serial-bus 8-bit I/O expander: bus slave on the serial clock, port and interrupt on ref_clk_in.
// Assumes the serial clock toggles at least three times while rst_in is high.
//
// Summary of operation
// - Input register read releases interrupt
// - Inputs back at last read release interrupt
// - Pointer 00h plus foreign read releases interrupt
// - Foreign read address acknowledged is that trigger
// - Power-on reset defaults registers and bus engine
// - Power-on reset is the only reset
`timescale 1ns/1ps
`default_nettype none
`include "iox_defines.svh"

module iox_expander_top (
	// System clock and power-on reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Serial bus, clock and open-drain data
	input wire logic scl_clk_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	// Address straps
	input wire logic [2:0] addr_pins_in,
	// Port pins
	input wire logic [7:0] port_pins_in,
	output logic [7:0] port_pins_out,
	output logic [7:0] port_pins_oe_out,
	// Open-drain interrupt, active low
	output logic irq_n_out,
	output logic irq_oe_out
);
	import iox_pkg::*;

	// ****************************************
	// Link domain signals
	// ****************************************
	logic sda_rise, srst1, srst2, start;
	logic [2:0] adr_s1, adr_s2;
	logic [7:0] pin_s1, pin_s2;
	iox_state_t st, next_st;
	logic [3:0] cnt, next_cnt;
	logic [7:0] shift, next_shift, rx_byte, rd_value;
	logic rw, next_rw;
	logic [7:0] ptr, next_ptr;
	logic [7:0] out_reg, next_out_reg, pol_reg, next_pol_reg, cfg_reg, next_cfg_reg;
	logic [7:0] tx, next_tx;
	logic next_sda_oe, clr_tog, next_clr_tog, port_tog, next_port_tog;

	// ****************************************
	// System domain signals
	// ****************************************
	logic pt_s1, pt_s2, pt_s3, next_port_upd;
	logic [7:0] next_port_out, next_port_oe;

	// ****************************************
	// Link sampling and reset
	// ****************************************
	// Data is sampled at the rising serial clock; all else acts on the falling one
	always_ff @(posedge scl_clk_in) begin
		sda_rise <= sda_in;
	end

	// High at rise and low at fall: start or repeated start
	assign start = sda_rise & ~sda_in;

	always_ff @(negedge scl_clk_in) begin
		srst1 <= rst_in;
		srst2 <= srst1;
		adr_s1 <= addr_pins_in;
		adr_s2 <= adr_s1;
		pin_s1 <= port_pins_in;
		pin_s2 <= pin_s1;
	end

	// ****************************************
	// Register read mux
	// ****************************************
	always_comb begin
		unique case (ptr)
			`IOX_CMD_INPUT: rd_value = pin_s2 ^ pol_reg;
			`IOX_CMD_OUTPUT: rd_value = out_reg;
			`IOX_CMD_POLARITY: rd_value = pol_reg;
			`IOX_CMD_CONFIG: rd_value = cfg_reg;
			default: rd_value = 8'h00;
		endcase
	end

	// ****************************************
	// Bus engine
	// ****************************************
	always_comb begin
		next_st = st;
		next_cnt = cnt;
		next_shift = shift;
		next_rw = rw;
		next_ptr = ptr;
		next_out_reg = out_reg;
		next_pol_reg = pol_reg;
		next_cfg_reg = cfg_reg;
		next_tx = tx;
		next_sda_oe = sda_oe_out;
		next_clr_tog = clr_tog;
		next_port_tog = port_tog;
		rx_byte = {shift[6:0], sda_rise};
		if (start) begin
			next_st = ST_ADDR;
			next_cnt = 4'h0;
			next_sda_oe = 1'b0;
		end else if (st == ST_IDLE) begin
			next_cnt = 4'h0;
		end else if (cnt != `IOX_ACK_SLOT) begin
			next_cnt = cnt + 4'h1;
			if (st == ST_RDATA) begin
				next_tx = {tx[6:0], 1'b1};
				if (cnt == `IOX_LAST_BIT) begin
					// Byte out; free the line for the master acknowledge
					next_sda_oe = 1'b0;
					if (ptr == `IOX_CMD_INPUT) begin
						next_clr_tog = ~clr_tog;
					end
				end else begin
					next_sda_oe = ~tx[6];
				end
			end else begin
				next_shift = rx_byte;
				if (cnt == `IOX_LAST_BIT) begin
					unique case (st)
						ST_ADDR: begin
							next_rw = rx_byte[0];
							if (rx_byte[7:1] == {`IOX_ADDR_PREFIX, adr_s2}) begin
								next_sda_oe = 1'b1;
							end else if (rx_byte[0]) begin
								next_st = ST_FOREIGN;
							end else begin
								next_st = ST_IDLE;
								next_cnt = 4'h0;
							end
						end
						ST_CMD: begin
							next_ptr = rx_byte;
							next_sda_oe = 1'b1;
						end
						ST_WDATA: begin
							next_sda_oe = 1'b1;
							unique case (ptr)
								`IOX_CMD_OUTPUT: begin
									next_out_reg = rx_byte;
									next_port_tog = ~port_tog;
								end
								`IOX_CMD_POLARITY: next_pol_reg = rx_byte;
								`IOX_CMD_CONFIG: begin
									next_cfg_reg = rx_byte;
									next_port_tog = ~port_tog;
								end
								default: next_pol_reg = pol_reg;
							endcase
						end
						default: next_sda_oe = 1'b0;
					endcase
				end
			end
		end else begin
			// End of the acknowledge slot
			next_cnt = 4'h0;
			next_sda_oe = 1'b0;
			unique case (st)
				ST_ADDR: begin
					if (rw) begin
						next_st = ST_RDATA;
						next_tx = rd_value;
						next_sda_oe = ~rd_value[7];
					end else begin
						next_st = ST_CMD;
					end
				end
				ST_CMD: next_st = ST_WDATA;
				ST_RDATA: begin
					if (!sda_rise) begin
						next_tx = rd_value;
						next_sda_oe = ~rd_value[7];
					end else begin
						next_st = ST_IDLE;
					end
				end
				ST_FOREIGN: begin
					// Another slave acknowledged a read while our pointer is 00h
					if (!sda_rise && ptr == `IOX_CMD_INPUT) begin
						next_clr_tog = ~clr_tog;
					end
					next_st = ST_IDLE;
				end
				default: next_st = st;
			endcase
		end
	end

	always_ff @(negedge scl_clk_in) begin
		if (srst2) begin
			st <= ST_IDLE;
			cnt <= 4'h0;
			shift <= 8'h00;
			rw <= 1'b0;
			ptr <= `IOX_RST_POINTER;
			out_reg <= `IOX_RST_OUTPUT;
			pol_reg <= `IOX_RST_POLARITY;
			cfg_reg <= `IOX_RST_CONFIG;
			tx <= 8'h00;
			sda_oe_out <= 1'b0;
			sda_out <= 1'b0;
			clr_tog <= 1'b0;
			port_tog <= 1'b0;
		end else begin
			st <= next_st;
			cnt <= next_cnt;
			shift <= next_shift;
			rw <= next_rw;
			ptr <= next_ptr;
			out_reg <= next_out_reg;
			pol_reg <= next_pol_reg;
			cfg_reg <= next_cfg_reg;
			tx <= next_tx;
			sda_oe_out <= next_sda_oe;
			sda_out <= 1'b0;
			clr_tog <= next_clr_tog;
			port_tog <= next_port_tog;
		end
	end

	// ****************************************
	// Port update crossing
	// ****************************************
	// Source words only change a full byte after the toggle, far above the sync delay
	always_comb begin
		next_port_upd = pt_s2 ^ pt_s3;
		next_port_out = port_pins_out;
		next_port_oe = port_pins_oe_out;
		if (next_port_upd) begin
			next_port_out = out_reg;
			next_port_oe = ~cfg_reg;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			pt_s1 <= 1'b0;
			pt_s2 <= 1'b0;
			pt_s3 <= 1'b0;
			port_pins_out <= `IOX_RST_OUTPUT;
			port_pins_oe_out <= ~`IOX_RST_CONFIG;
			irq_n_out <= 1'b0;
		end else begin
			pt_s1 <= port_tog;
			pt_s2 <= pt_s1;
			pt_s3 <= pt_s2;
			port_pins_out <= next_port_out;
			port_pins_oe_out <= next_port_oe;
			irq_n_out <= 1'b0;
		end
	end

	// ****************************************
	// Interrupt
	// ****************************************
	iox_irq u_irq (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.port_pins_in(port_pins_in),
		.input_mask_in(~port_pins_oe_out),
		.clr_tog_in(clr_tog),
		.irq_oe_out(irq_oe_out)
	);

	// ****************************************
	// Checks
	// ****************************************
	a_foreign_clear: assert property (@(negedge scl_clk_in) disable iff (srst2)
		!start && st == ST_FOREIGN && cnt == `IOX_ACK_SLOT && !sda_rise && ptr == 8'h00
		|=> clr_tog != $past(clr_tog) && st == ST_IDLE)
		else $error("foreign read with pointer 00h did not clear");
	a_pointer_guard: assert property (@(negedge scl_clk_in) disable iff (srst2)
		st == ST_FOREIGN && ptr != 8'h00 |=> $stable(clr_tog))
		else $error("foreign read cleared with nonzero pointer");
	a_foreign_silent: assert property (@(negedge scl_clk_in) disable iff (srst2)
		st == ST_FOREIGN |-> !sda_oe_out)
		else $error("data line driven during foreign transfer");
	a_read_clear: assert property (@(negedge scl_clk_in) disable iff (srst2)
		!start && st == ST_RDATA && cnt == `IOX_LAST_BIT && ptr == 8'h00
		|=> clr_tog != $past(clr_tog) && !sda_oe_out)
		else $error("input register read did not clear");
	a_link_reset: assert property (@(negedge scl_clk_in)
		srst2 |=> st == ST_IDLE && ptr == 8'h00 && cfg_reg == 8'hff && !sda_oe_out)
		else $error("link registers not defaulted by reset");
	a_port_follow: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		pt_s2 != pt_s3 |=> port_pins_oe_out == ~$past(cfg_reg))
		else $error("port direction did not follow configuration");

	c_foreign_clear: cover property (@(negedge scl_clk_in) disable iff (srst2)
		st == ST_FOREIGN && cnt == `IOX_ACK_SLOT && !sda_rise && ptr == 8'h00);
	c_input_read: cover property (@(negedge scl_clk_in) disable iff (srst2)
		st == ST_RDATA && cnt == `IOX_LAST_BIT && ptr == 8'h00);
	c_config_write: cover property (@(negedge scl_clk_in) disable iff (srst2)
		st == ST_WDATA && cnt == `IOX_LAST_BIT && ptr == 8'h03);
	c_irq_cycle: cover property (@(posedge ref_clk_in) disable iff (rst_in)
		irq_oe_out ##[1:400] !irq_oe_out);
endmodule

`default_nettype wire

// *** tb/iox_bus_master.sv ***
// Bus master model: makes the serial clock and pulls the data wire low.
// Assumes a pull-up on the data wire, resolved by the bench from all drivers.
`timescale 1ns/1ps
`default_nettype none

module iox_bus_master (
	// Serial bus
	output logic scl_out,
	output logic sda_low_out,
	input wire logic sda_in
);
	// ****************************************
	// Bit and byte level
	// ****************************************
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end

	// Entered just after a falling edge; data moves only while the clock is low
	task automatic bit_io(input logic b, output logic s);
		#4 sda_low_out = !b;
		#20 scl_out = 1'b1;
		s = sda_in;
		#24 scl_out = 1'b0;
	endtask

	// Clock with the wire released, run through the device's power-on reset and on past its release
	task automatic idle_clk(input int n);
		repeat (n) begin
			#24 scl_out = 1'b0;
			#24 scl_out = 1'b1;
		end
	endtask

	task automatic start();
		#12 scl_out = 1'b0;
		#12 sda_low_out = 1'b0;
		#24 scl_out = 1'b1;
		#12 sda_low_out = 1'b1;
		#12 scl_out = 1'b0;
	endtask

	// Clock then stands still high between frames
	task automatic stop();
		#4 sda_low_out = 1'b1;
		#20 scl_out = 1'b1;
		#12 sda_low_out = 1'b0;
		#12;
	endtask

	// Other slave's acknowledge is played here when asked for
	task automatic send_byte(input logic [7:0] b, input logic other_ack, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(!other_ack, s);
		ack = !s;
	endtask

	task automatic recv_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(last, s);
	endtask
endmodule

`default_nettype wire

// *** tb/test_io_expander_irq_and_reset.sv ***
// Testbench of the expander's interrupt release and power-on defaults.
// Assumes the package, the design and the bus master model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "iox_defines.svh"

module test_io_expander_irq_and_reset;
	import iox_pkg::*;
	localparam logic [2:0] STRAP = 3'h5;
	localparam logic [6:0] DEV = {`IOX_ADDR_PREFIX, STRAP};
	localparam logic [6:0] OTHER = 7'h50;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] tb_pins = 8'hff;
	logic scl, m_low, sda, sda_drv, sda_oe, irq_n, irq_oe;
	logic [7:0] pin_out, pin_oe, pins;
	int n_mismatch = 0;
	int compares = 0;

	// ****************************************
	// Clock, wires and instances
	// ****************************************
	always #12.5 ref_clk_in = !ref_clk_in;
	assign pins = (pin_oe & pin_out) | (~pin_oe & tb_pins);
	assign sda = !(m_low | (sda_oe & !sda_drv));

	iox_bus_master mdl_u (
		.scl_out(scl),
		.sda_low_out(m_low),
		.sda_in(sda)
	);

	iox_expander_top dut_u (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.scl_clk_in(scl),
		.sda_in(sda),
		.sda_out(sda_drv),
		.sda_oe_out(sda_oe),
		.addr_pins_in(STRAP),
		.port_pins_in(pins),
		.port_pins_out(pin_out),
		.port_pins_oe_out(pin_oe),
		.irq_n_out(irq_n),
		.irq_oe_out(irq_oe)
	);

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Sync plus clear latency is at most four edges
	task automatic settle();
		repeat (8) @(posedge ref_clk_in);
		#2;
	endtask

	task automatic set_pins(input logic [7:0] v);
		@(posedge ref_clk_in);
		#2 tb_pins = v;
		settle();
	endtask

	task automatic chk_irq(input logic exp);
		chk({6'h0, irq_n, irq_oe}, {7'h0, exp});
	endtask

	// Scl must run during reset so the link side sees it too
	task automatic do_reset();
		fork
			mdl_u.idle_clk(10);
			begin
				@(posedge ref_clk_in);
				#2 rst_in = 1'b1;
				repeat (10) @(posedge ref_clk_in);
				#2 rst_in = 1'b0;
			end
		join
	endtask

	// Bit 8 of d set means a data byte follows the command
	task automatic wr(input logic [7:0] cmd, input logic [8:0] d);
		logic a0, a1, a2;
		a2 = 1'b1;
		mdl_u.start();
		mdl_u.send_byte({DEV, 1'b0}, 1'b0, a0);
		mdl_u.send_byte(cmd, 1'b0, a1);
		if (d[8]) mdl_u.send_byte(d[7:0], 1'b0, a2);
		mdl_u.stop();
		settle();
		chk({5'h0, a0, a1, a2}, 8'h07);
	endtask

	task automatic rd(input logic [6:0] a, input logic other, input logic [7:0] exp);
		logic ack;
		logic [7:0] d;
		mdl_u.start();
		mdl_u.send_byte({a, 1'b1}, other, ack);
		if (a == DEV) mdl_u.recv_byte(1'b1, d);
		mdl_u.stop();
		settle();
		if (a == DEV) chk(d, exp);
		chk({7'h0, ack}, {7'h0, (a == DEV) | other});
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_defaults();
		chk(pin_oe, 8'h00);
		chk(pin_out, `IOX_RST_OUTPUT);
		chk_irq(1'b0);
		chk({7'h0, sda_oe}, 8'h00);
		wr(`IOX_CMD_CONFIG, 9'h000);
		rd(DEV, 1'b0, `IOX_RST_CONFIG);
		wr(`IOX_CMD_POLARITY, 9'h000);
		rd(DEV, 1'b0, `IOX_RST_POLARITY);
	endtask

	task automatic t_read_clear();
		set_pins(8'h5a);
		chk_irq(1'b1);
		wr(`IOX_CMD_INPUT, 9'h000);
		chk_irq(1'b1);
		rd(DEV, 1'b0, 8'h5a);
		chk_irq(1'b0);
	endtask

	task automatic t_return();
		set_pins(8'h5b);
		chk_irq(1'b1);
		set_pins(8'h5a);
		chk_irq(1'b0);
	endtask

	// Pointer is still 00h from the input read before
	task automatic t_foreign();
		set_pins(8'h7a);
		rd(OTHER, 1'b0, 8'h00);
		chk_irq(1'b1);
		rd(OTHER, 1'b1, 8'h00);
		chk_irq(1'b0);
		wr(`IOX_CMD_CONFIG, 9'h13f);
		chk(pin_oe, 8'hc0);
		wr(`IOX_CMD_OUTPUT, 9'h13f);
		chk(pin_out, 8'h3f);
		chk_irq(1'b0);
		set_pins(8'h7b);
		rd(OTHER, 1'b1, 8'h00);
		chk_irq(1'b1);
		wr(`IOX_CMD_INPUT, 9'h000);
		rd(DEV, 1'b0, 8'h3b);
		chk_irq(1'b0);
		chk(pin_oe, 8'hc0);
	endtask

	// Inverted input read, ignored write to 00h, pointer above 03h
	task automatic t_polarity();
		wr(`IOX_CMD_POLARITY, 9'h1ff);
		wr(`IOX_CMD_INPUT, 9'h1ff);
		rd(DEV, 1'b0, 8'h84);
		chk_irq(1'b0);
		wr(8'h07, 9'h000);
		rd(DEV, 1'b0, 8'h00);
		set_pins(8'h7a);
		chk_irq(1'b1);
		rd(OTHER, 1'b1, 8'h00);
		chk_irq(1'b1);
	endtask

	initial begin
		do_reset();
		t_defaults();
		t_read_clear();
		t_return();
		t_foreign();
		do_reset();
		t_defaults();
		t_polarity();
		end_sim();
	end

	// Whole run needs some 30 us
	initial begin
		#200000;
		n_mismatch++;
		end_sim();
	end
endmodule

`default_nettype wire
